// file: hw/gml_pkg.sv
package gml_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int RST_MIN_NS      = 10000;
    localparam int RST_MIN_CYC     = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LOR_BASE_NS     = 80000;
    localparam int LOR_BASE_CYC    = (LOR_BASE_NS * 1000) / CLK_PERIOD_PS;
    localparam int H_ERR_STEP_NS   = 4000;
    localparam int H_ERR_STEP_CYC  = (H_ERR_STEP_NS * 1000) / CLK_PERIOD_PS;
    localparam int LOR_CNT_W       = 24;

    // Register indices and byte addresses
    localparam int                ADDR_W      = 12;
    localparam logic [9:0]        IDX_MODE    = 10'h000;
    localparam logic [9:0]        IDX_REFDIV  = 10'h003;
    localparam logic [9:0]        IDX_LOOPDIV = 10'h004;
    localparam logic [9:0]        IDX_STATUS  = 10'h006;
    localparam logic [ADDR_W-1:0] ADDR_MODE    = {IDX_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_REFDIV  = {IDX_REFDIV, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_LOOPDIV = {IDX_LOOPDIV, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};

    // Mode register fields
    localparam int MODE_W        = 8;
    localparam int MODE_SEL_BIT  = 0;
    localparam int HOLDOVER_BIT  = 1;
    localparam int PORT_SEL_BIT  = 2;
    localparam int PORT_SRC_BIT  = 3;
    localparam int H_ERR_LSB     = 4;
    localparam int H_ERR_W       = 4;
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;

    // Divider fields
    localparam int REFDIV_W   = 2;
    localparam int LOOPDIV_W  = 13;
    localparam int RATIO_W    = 3;
    localparam logic [REFDIV_W-1:0]  REFDIV_RST     = 2'h1;
    localparam logic [LOOPDIV_W-1:0] LOOPDIV_RST    = 13'h0001;
    localparam logic [REFDIV_W-1:0]  REFDIV_CODE_D2 = 2'h0;
    localparam logic [REFDIV_W-1:0]  REFDIV_CODE_D1 = 2'h1;
    localparam logic [REFDIV_W-1:0]  REFDIV_CODE_D5 = 2'h2;
    localparam logic [RATIO_W-1:0]   RATIO_D1       = 3'h1;
    localparam logic [RATIO_W-1:0]   RATIO_D2       = 3'h2;
    localparam logic [RATIO_W-1:0]   RATIO_D5       = 3'h5;

    // Status register fields
    localparam int ST_NO_REF_BIT  = 0;
    localparam int ST_NO_LOCK_BIT = 1;
    localparam int ST_PORT_BIT    = 2;
    localparam int ST_GEN_BIT     = 3;
    localparam int ST_STATE_LSB   = 4;

    // Pin synchroniser lanes
    localparam int SYN_W      = 6;
    localparam int SYN_HA     = 0;
    localparam int SYN_HB     = 1;
    localparam int SYN_VCXO   = 2;
    localparam int SYN_LOCK   = 3;
    localparam int SYN_MODE_N = 4;
    localparam int SYN_PSEL   = 5;
    localparam logic [SYN_W-1:0] SYN_RST = 6'h10;

    typedef enum logic [4:0] {
        ST_FREE     = 5'h01,
        ST_ACQ      = 5'h02,
        ST_LOCK     = 5'h04,
        ST_LOR_FREE = 5'h08,
        ST_LOR_HOLD = 5'h10
    } gml_state_t;

endpackage : gml_pkg

// file: hw/gml_ref_monitor.sv
`timescale 1ns/1ps
module gml_ref_monitor #(
    parameter int BASE_CYC = gml_pkg::LOR_BASE_CYC,
    parameter int STEP_CYC = gml_pkg::H_ERR_STEP_CYC,
    parameter int CNT_W    = gml_pkg::LOR_CNT_W
) (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        sync_edge,
    input  wire logic                        restart,
    input  wire logic [gml_pkg::H_ERR_W-1:0] h_error,
    output logic                             ref_loss
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             loss_q;
    logic             loss_d;
    logic [CNT_W-1:0] limit;
    logic             expired;

    assign limit   = CNT_W'(BASE_CYC) + CNT_W'(h_error) * CNT_W'(STEP_CYC);
    assign expired = (cnt_q >= limit);
    assign cnt_d   = (sync_edge || restart) ? '0 : (expired ? cnt_q : cnt_q + 1'b1);
    assign loss_d  = sync_edge ? 1'b0 : (loss_q | (expired && !restart));
    assign ref_loss = loss_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            loss_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_d;
            loss_q <= loss_d;
        end
    end

endmodule : gml_ref_monitor

// file: hw/gml_mode_ctrl.sv
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Mode bit clear with pin high gives free run
// - Mode bit set locks to selected H sync
// - Low pin selects genlock when bit clear
// - Free run closes idle voltage switch
// - Locked genlock enables output alignment
// - Reference format may differ from output
// - Genlock keeps trying despite unstable input
// - Every state drives reference and lock flags
// - Loss without holdover falls to free run
// - Loss with holdover enters holdover
// - Returning reference resumes locking at once
// - Genlock free runs only during loss
// - Holdover floats loop filter on the same edge as loss flag
// - Error setting sets loss threshold
// - Port chosen by bit or pin
// - Loop divider 1 to 8191, zero invalid
// - Reference divider codes 0,1,2 give 2,1,5
// - Reset defaults to free run
// - Reset held low at least 10 us; nothing checks this, and the testbench releases it after 6 clocks
module gml_mode_ctrl #(
    parameter int LOR_BASE_CYC   = gml_pkg::LOR_BASE_CYC,
    parameter int H_ERR_STEP_CYC = gml_pkg::H_ERR_STEP_CYC
) (
    input  wire logic                       ref_clk,
    input  wire logic                       rst_n,
    input  wire logic [gml_pkg::ADDR_W-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       hsync_a,
    input  wire logic                       hsync_b,
    input  wire logic                       vcxo_clk_in,
    input  wire logic                       pll_lock_in,
    input  wire logic                       mode_select_pin_n,
    input  wire logic                       port_select_pin,
    output logic                            idle_voltage_switch,
    output logic                            loop_filter_hiz,
    output logic                            phase_detect_en,
    output logic                            output_align_en,
    output logic                            ref_cmp_pulse,
    output logic                            fb_cmp_pulse,
    output logic                            selected_port,
    output logic                            reference_loss,
    output logic                            no_lock
);
    // Pin synchroniser lanes
    logic [gml_pkg::SYN_W-1:0]     syn_raw;
    logic [gml_pkg::SYN_W-1:0]     syn_meta_q;
    logic [gml_pkg::SYN_W-1:0]     syn_q;

    // Sync edge detectors, idle low
    logic                          ha_prev_q;
    logic                          hb_prev_q;
    logic                          vcxo_prev_q;
    logic                          edge_a;
    logic                          edge_b;
    logic                          vcxo_edge;

    // Control registers
    logic [gml_pkg::MODE_W-1:0]    mode_q;
    logic [gml_pkg::MODE_W-1:0]    mode_d;
    logic [gml_pkg::REFDIV_W-1:0]  refdiv_q;
    logic [gml_pkg::REFDIV_W-1:0]  refdiv_d;
    logic [gml_pkg::LOOPDIV_W-1:0] loopdiv_q;
    logic [gml_pkg::LOOPDIV_W-1:0] loopdiv_d;

    // Bus handshake
    logic                          access;
    logic                          wr_fire;
    logic                          sel_mode;
    logic                          sel_refdiv;
    logic                          sel_loopdiv;
    logic                          sel_status;
    logic                          addr_bad;
    logic                          wr_bad;
    logic                          refdiv_ok;
    logic                          loopdiv_ok;
    logic [31:0]                   rd_word;
    logic [31:0]                   status_word;
    logic [31:0]                   prdata_q;
    logic [31:0]                   prdata_d;
    logic                          pready_q;
    logic                          pready_d;
    logic                          pslverr_q;
    logic                          pslverr_d;

    // Mode and reference selection
    logic                          gen_mode;
    logic                          lock_w;
    logic                          loss_w;
    logic                          port_q;
    logic                          port_d;
    logic                          port_change;
    logic                          sel_edge;
    logic [gml_pkg::H_ERR_W-1:0]   h_error;
    gml_pkg::gml_state_t           state_q;
    gml_pkg::gml_state_t           state_d;
    gml_pkg::gml_state_t           lor_target;

    // Registered outputs
    logic                          idle_sw_q;
    logic                          idle_sw_d;
    logic                          hiz_q;
    logic                          hiz_d;
    logic                          pd_en_q;
    logic                          pd_en_d;
    logic                          align_q;
    logic                          align_d;
    logic                          ref_loss_q;
    logic                          no_lock_q;

    // Phase comparator dividers
    logic [gml_pkg::RATIO_W-1:0]   ratio;
    logic [gml_pkg::RATIO_W-1:0]   ref_cnt_q;
    logic [gml_pkg::RATIO_W-1:0]   ref_cnt_d;
    logic                          ref_last;
    logic                          ref_pulse_q;
    logic [gml_pkg::LOOPDIV_W-1:0] fb_cnt_q;
    logic [gml_pkg::LOOPDIV_W-1:0] fb_cnt_d;
    logic                          fb_last;
    logic                          fb_pulse_q;

    assign syn_raw[gml_pkg::SYN_HA]     = hsync_a;
    assign syn_raw[gml_pkg::SYN_HB]     = hsync_b;
    assign syn_raw[gml_pkg::SYN_VCXO]   = vcxo_clk_in;
    assign syn_raw[gml_pkg::SYN_LOCK]   = pll_lock_in;
    assign syn_raw[gml_pkg::SYN_MODE_N] = mode_select_pin_n;
    assign syn_raw[gml_pkg::SYN_PSEL]   = port_select_pin;

    // Two flops per pin lane
    generate
        for (genvar i = 0; i < gml_pkg::SYN_W; i++) begin : g_syn
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    syn_meta_q[i] <= gml_pkg::SYN_RST[i];
                    syn_q[i]      <= gml_pkg::SYN_RST[i];
                end else begin
                    syn_meta_q[i] <= syn_raw[i];
                    syn_q[i]      <= syn_meta_q[i];
                end
            end
        end
    endgenerate

    assign edge_a    = syn_q[gml_pkg::SYN_HA] && !ha_prev_q;
    assign edge_b    = syn_q[gml_pkg::SYN_HB] && !hb_prev_q;
    assign vcxo_edge = syn_q[gml_pkg::SYN_VCXO] && !vcxo_prev_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ha_prev_q   <= 1'b0;
            hb_prev_q   <= 1'b0;
            vcxo_prev_q <= 1'b0;
        end else begin
            ha_prev_q   <= syn_q[gml_pkg::SYN_HA];
            hb_prev_q   <= syn_q[gml_pkg::SYN_HB];
            vcxo_prev_q <= syn_q[gml_pkg::SYN_VCXO];
        end
    end

    // Bus: one wait state, then ready
    assign access      = psel && penable && !pready_q;
    assign wr_fire     = psel && penable && pready_q && pwrite;
    assign sel_mode    = (paddr == gml_pkg::ADDR_MODE);
    assign sel_refdiv  = (paddr == gml_pkg::ADDR_REFDIV);
    assign sel_loopdiv = (paddr == gml_pkg::ADDR_LOOPDIV);
    assign sel_status  = (paddr == gml_pkg::ADDR_STATUS);

    assign refdiv_ok  = (pwdata[gml_pkg::REFDIV_W-1:0] == gml_pkg::REFDIV_CODE_D2)
                     || (pwdata[gml_pkg::REFDIV_W-1:0] == gml_pkg::REFDIV_CODE_D1)
                     || (pwdata[gml_pkg::REFDIV_W-1:0] == gml_pkg::REFDIV_CODE_D5);
    assign loopdiv_ok = (pwdata[gml_pkg::LOOPDIV_W-1:0] != '0);

    always_comb begin
        status_word = '0;
        status_word[gml_pkg::ST_NO_REF_BIT]  = ref_loss_q;
        status_word[gml_pkg::ST_NO_LOCK_BIT] = no_lock_q;
        status_word[gml_pkg::ST_PORT_BIT]    = port_q;
        status_word[gml_pkg::ST_GEN_BIT]     = gen_mode;
        status_word[gml_pkg::ST_STATE_LSB +: $bits(gml_pkg::gml_state_t)] = state_q;
    end

    always_comb begin
        rd_word  = '0;
        addr_bad = 1'b0;
        wr_bad   = 1'b0;
        if (sel_mode) begin
            rd_word = 32'(mode_q);
        end else if (sel_refdiv) begin
            rd_word = 32'(refdiv_q);
            wr_bad  = pwrite && !refdiv_ok;
        end else if (sel_loopdiv) begin
            rd_word = 32'(loopdiv_q);
            wr_bad  = pwrite && !loopdiv_ok;
        end else if (sel_status) begin
            rd_word = status_word;
            wr_bad  = pwrite;
        end else begin
            addr_bad = 1'b1;
        end
    end

    assign pready_d  = access;
    assign prdata_d  = access ? rd_word : prdata_q;
    assign pslverr_d = access && (addr_bad || wr_bad);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // Writes land at the ready edge
    assign mode_d    = (wr_fire && sel_mode) ? pwdata[gml_pkg::MODE_W-1:0] : mode_q;
    assign refdiv_d  = (wr_fire && sel_refdiv && refdiv_ok) ? pwdata[gml_pkg::REFDIV_W-1:0] : refdiv_q;
    assign loopdiv_d = (wr_fire && sel_loopdiv && loopdiv_ok) ? pwdata[gml_pkg::LOOPDIV_W-1:0] : loopdiv_q;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q    <= gml_pkg::MODE_RST;
            refdiv_q  <= gml_pkg::REFDIV_RST;
            loopdiv_q <= gml_pkg::LOOPDIV_RST;
        end else begin
            mode_q    <= mode_d;
            refdiv_q  <= refdiv_d;
            loopdiv_q <= loopdiv_d;
        end
    end

    assign gen_mode = mode_q[gml_pkg::MODE_SEL_BIT] || !syn_q[gml_pkg::SYN_MODE_N];
    assign lock_w   = syn_q[gml_pkg::SYN_LOCK];
    assign port_d      = mode_q[gml_pkg::PORT_SRC_BIT] ? mode_q[gml_pkg::PORT_SEL_BIT]
                                                       : syn_q[gml_pkg::SYN_PSEL];
    assign port_change = (port_d != port_q);
    assign sel_edge    = port_q ? edge_b : edge_a;
    assign h_error     = mode_q[gml_pkg::H_ERR_LSB +: gml_pkg::H_ERR_W];

    gml_ref_monitor #(
        .BASE_CYC (LOR_BASE_CYC),
        .STEP_CYC (H_ERR_STEP_CYC),
        .CNT_W    (gml_pkg::LOR_CNT_W)
    ) u_ref_monitor (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .sync_edge (sel_edge),
        .restart   (port_change),
        .h_error   (h_error),
        .ref_loss  (loss_w)
    );

    assign lor_target = mode_q[gml_pkg::HOLDOVER_BIT] ? gml_pkg::ST_LOR_HOLD : gml_pkg::ST_LOR_FREE;

    always_comb begin
        state_d = state_q;
        case (state_q)
            gml_pkg::ST_FREE: begin
                if (gen_mode && loss_w) begin
                    state_d = lor_target;
                end else if (gen_mode) begin
                    state_d = gml_pkg::ST_ACQ;
                end
            end
            gml_pkg::ST_ACQ: begin
                if (!gen_mode) begin
                    state_d = gml_pkg::ST_FREE;
                end else if (loss_w) begin
                    state_d = lor_target;
                end else if (lock_w) begin
                    state_d = gml_pkg::ST_LOCK;
                end
            end
            gml_pkg::ST_LOCK: begin
                if (!gen_mode) begin
                    state_d = gml_pkg::ST_FREE;
                end else if (loss_w) begin
                    state_d = lor_target;
                end else if (!lock_w) begin
                    state_d = gml_pkg::ST_ACQ;
                end
            end
            gml_pkg::ST_LOR_FREE, gml_pkg::ST_LOR_HOLD: begin
                if (!gen_mode) begin
                    state_d = gml_pkg::ST_FREE;
                end else if (!loss_w) begin
                    state_d = lock_w ? gml_pkg::ST_LOCK : gml_pkg::ST_ACQ;
                end else begin
                    state_d = lor_target;
                end
            end
            default: begin
                state_d = gml_pkg::ST_FREE;
            end
        endcase
    end

    assign idle_sw_d = (state_d == gml_pkg::ST_FREE) || (state_d == gml_pkg::ST_LOR_FREE);
    assign hiz_d     = (state_d == gml_pkg::ST_LOR_HOLD);
    assign pd_en_d   = (state_d == gml_pkg::ST_ACQ) || (state_d == gml_pkg::ST_LOCK);
    assign align_d   = (state_d == gml_pkg::ST_LOCK);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= gml_pkg::ST_FREE;
            port_q     <= 1'b0;
            idle_sw_q  <= 1'b1;
            hiz_q      <= 1'b0;
            pd_en_q    <= 1'b0;
            align_q    <= 1'b0;
            ref_loss_q <= 1'b1;
            no_lock_q  <= 1'b1;
        end else begin
            state_q    <= state_d;
            port_q     <= port_d;
            idle_sw_q  <= idle_sw_d;
            hiz_q      <= hiz_d;
            pd_en_q    <= pd_en_d;
            align_q    <= align_d;
            ref_loss_q <= loss_w;
            no_lock_q  <= !lock_w;
        end
    end

    assign ratio     = (refdiv_q == gml_pkg::REFDIV_CODE_D2) ? gml_pkg::RATIO_D2 :
                       (refdiv_q == gml_pkg::REFDIV_CODE_D5) ? gml_pkg::RATIO_D5 : gml_pkg::RATIO_D1;
    assign ref_last  = (ref_cnt_q >= (ratio - gml_pkg::RATIO_W'(1)));
    assign fb_last   = (fb_cnt_q >= (loopdiv_q - gml_pkg::LOOPDIV_W'(1)));
    assign ref_cnt_d = !pd_en_q ? '0 :
                       (!sel_edge ? ref_cnt_q : (ref_last ? '0 : ref_cnt_q + gml_pkg::RATIO_W'(1)));
    assign fb_cnt_d  = !pd_en_q ? '0 :
                       (!vcxo_edge ? fb_cnt_q : (fb_last ? '0 : fb_cnt_q + gml_pkg::LOOPDIV_W'(1)));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_cnt_q   <= '0;
            fb_cnt_q    <= '0;
            ref_pulse_q <= 1'b0;
            fb_pulse_q  <= 1'b0;
        end else begin
            ref_cnt_q   <= ref_cnt_d;
            fb_cnt_q    <= fb_cnt_d;
            ref_pulse_q <= pd_en_q && sel_edge && ref_last;
            fb_pulse_q  <= pd_en_q && vcxo_edge && fb_last;
        end
    end

    assign prdata              = prdata_q;
    assign pready              = pready_q;
    assign pslverr             = pslverr_q;
    assign idle_voltage_switch = idle_sw_q;
    assign loop_filter_hiz     = hiz_q;
    assign phase_detect_en     = pd_en_q;
    assign output_align_en     = align_q;
    assign ref_cmp_pulse       = ref_pulse_q;
    assign fb_cmp_pulse        = fb_pulse_q;
    assign selected_port       = port_q;
    assign reference_loss      = ref_loss_q;
    assign no_lock             = no_lock_q;

    AST_FREE_RUN : assert property (@(posedge ref_clk) disable iff (!rst_n)
        !gen_mode |=> state_q == gml_pkg::ST_FREE)
        else $error("free run not entered");

    AST_FREE_SWITCH : assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == gml_pkg::ST_FREE |-> idle_sw_q)
        else $error("idle switch open in free run");

    AST_LOSS_FREE : assert property (@(posedge ref_clk) disable iff (!rst_n)
        gen_mode && loss_w && !mode_q[gml_pkg::HOLDOVER_BIT] |=> state_q == gml_pkg::ST_LOR_FREE)
        else $error("loss did not fall to free run");

    AST_LOSS_HOLD : assert property (@(posedge ref_clk) disable iff (!rst_n)
        gen_mode && loss_w && mode_q[gml_pkg::HOLDOVER_BIT] |=> state_q == gml_pkg::ST_LOR_HOLD)
        else $error("loss did not enter holdover");

    AST_RESUME : assert property (@(posedge ref_clk) disable iff (!rst_n)
        gen_mode && !loss_w |=> (state_q == gml_pkg::ST_ACQ) || (state_q == gml_pkg::ST_LOCK))
        else $error("present reference not tracked");

    AST_HOLD_HIZ : assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == gml_pkg::ST_LOR_HOLD |-> hiz_q && !idle_sw_q)
        else $error("filter not floating in holdover");

    AST_FLAGS : assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> (ref_loss_q == $past(loss_w)) && (no_lock_q != $past(lock_w)))
        else $error("status flags out of step");

    AST_LOOPDIV_NZ : assert property (@(posedge ref_clk) disable iff (!rst_n)
        loopdiv_q != '0)
        else $error("loop divider zero");

    AST_REFDIV_CODE : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (refdiv_q == gml_pkg::REFDIV_CODE_D2) || (refdiv_q == gml_pkg::REFDIV_CODE_D1)
        || (refdiv_q == gml_pkg::REFDIV_CODE_D5))
        else $error("reference divider code invalid");

endmodule : gml_mode_ctrl

// file: tb/gml_sync_src.sv
`timescale 1ns/1ps
module gml_sync_src (
    input  wire logic clk,
    input  wire logic run_a,
    input  wire logic run_b,
    output logic      hs_a = 1'b0,
    output logic      hs_b = 1'b0
);
    int cnt = 0;
    always @(posedge clk) begin
        cnt <= (cnt + 1) % 40;
        hs_a <= run_a && cnt == 0;
        hs_b <= run_b && cnt == 20;
    end
endmodule : gml_sync_src

// file: tb/genlock_mode_reference_control_tb.sv
`timescale 1ns/1ps
module genlock_mode_reference_control_tb;
    logic        ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic        vcxo = 0, lock = 0, pin_n = 1, psel_pin = 0, run_a = 1, run_b = 1;
    logic        hs_a, hs_b, pready, pslverr, idle_sw, hiz, sel_port, ref_loss, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    int          fails = 0, checks = 0, seed = 32'hd6cf67ef, mdl [int];
    gml_sync_src src (.clk(ref_clk), .run_a(run_a), .run_b(run_b), .hs_a(hs_a), .hs_b(hs_b));
    gml_mode_ctrl #(.LOR_BASE_CYC(100), .H_ERR_STEP_CYC(10)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hsync_a(hs_a), .hsync_b(hs_b), .vcxo_clk_in(vcxo),
        .pll_lock_in(lock), .mode_select_pin_n(pin_n), .port_select_pin(psel_pin),
        .idle_voltage_switch(idle_sw), .loop_filter_hiz(hiz), .phase_detect_en(), .output_align_en(),
        .ref_cmp_pulse(), .fb_cmp_pulse(), .selected_port(sel_port), .reference_loss(ref_loss), .no_lock());
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) vcxo <= ~vcxo;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
        if (pready !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t bus timeout", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (w && (a != gml_pkg::ADDR_LOOPDIV || d != 0)) mdl[a] = d;
        @(posedge ref_clk);
    endtask : apb
    task automatic mode(input logic [7:0] m, input int t, input logic e_sw, input logic e_hiz);
        apb(1, gml_pkg::ADDR_MODE, {24'h0, m});
        repeat (t) @(posedge ref_clk);
        chk(idle_sw, e_sw);
        chk(hiz, e_hiz);
        $display("step %h done", m);
    endtask : mode
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    initial begin
        #100us;
        fails++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        rst_n <= 1;
        lock <= 1;
        @(posedge ref_clk);
        apb(0, gml_pkg::ADDR_MODE, 0);
        chk(rd, 0);
        for (int i = 0; i < 3; i++) begin
            apb(1, gml_pkg::ADDR_LOOPDIV, 1 + ($unsigned($random(seed)) % 8191));
            apb(0, gml_pkg::ADDR_LOOPDIV, 0);
            chk(rd, mdl[gml_pkg::ADDR_LOOPDIV]);
            apb(1, gml_pkg::ADDR_REFDIV, i);
            apb(0, gml_pkg::ADDR_REFDIV, 0);
            chk(rd, i);
        end
        apb(1, gml_pkg::ADDR_LOOPDIV, 0);
        chk(err, 1);
        apb(0, gml_pkg::ADDR_LOOPDIV, 0);
        chk(rd, mdl[gml_pkg::ADDR_LOOPDIV]);
        apb(0, 12'hffc, 0);
        mode(8'h00, 20, 1, 0);
        mode(8'h01, 20, 0, 0);
        pin_n <= 0;
        mode(8'h00, 20, 0, 0);
        pin_n <= 1;
        mode(8'h0d, 20, 0, 0);
        chk(sel_port, 1);
        run_a <= 0;
        mode(8'h09, 300, 1, 0);
        chk(ref_loss, 1);
        run_a <= 1;
        mode(8'h09, 100, 0, 0);
        run_a <= 0;
        mode(8'h0b, 300, 0, 1);
        complete_run();
    end
endmodule : genlock_mode_reference_control_tb
